/* File: common/lpc_pkg.sv */
// constants, register map and state codes of the low-power wait/stop control
// assumes one 200 MHz core clock and an APB master for software access
package lpc_pkg;

  // apb byte addresses
  localparam logic [7:0] LPC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] LPC_ADDR_STATUS = 8'h04;

  // control register bit positions
  localparam int LPC_CTRL_RESTART_DELAY_EN = 0;
  localparam int LPC_CTRL_CONV_POWER_UP = 1;
  localparam int LPC_CTRL_SERIAL_EN = 2;
  localparam int LPC_CTRL_TX_EN = 3;
  localparam int LPC_CTRL_RX_EN = 4;
  localparam int LPC_CTRL_WATCHDOG_OFF = 5;
  localparam logic [5:0] LPC_CTRL_RESET = 6'h01;

  // status register field positions
  localparam int LPC_STAT_STATE_LSB = 0;
  localparam int LPC_STAT_ACT_LSB = 3;
  localparam int LPC_STAT_HALT = 5;

  // oscillator restart delay in oscillator cycles
  localparam int LPC_OSC_DELAY_CYCLES = 4064;
  localparam logic [15:0] LPC_CNT_ZERO = 16'h0000;
  localparam logic [15:0] LPC_CNT_ONE = 16'h0001;

  typedef enum logic [2:0] {
    LPC_RUN = 3'b000,
    LPC_WAIT_STACK = 3'b001,
    LPC_WAIT_IDLE = 3'b010,
    LPC_STOP = 3'b011,
    LPC_OSC_DELAY = 3'b100,
    LPC_WAKE_ACT = 3'b101,
    LPC_XSTACK = 3'b110
  } lpc_state_t;

  // what to do once the oscillator is stable again
  typedef enum logic [1:0] {
    LPC_ACT_NONE = 2'b00,
    LPC_ACT_RESUME = 2'b01,
    LPC_ACT_RESET = 2'b10,
    LPC_ACT_NMI = 2'b11
  } lpc_act_t;

endpackage

/* File: rtl/lpc_wait_stop_ctrl.sv */
// low-power wait and stop sequencing with apb control/status registers
// assumes cpu sequencer handshakes are synchronous single-cycle pulses
// and pin levels are already synchronous to sys_clk
`timescale 1ns/1ps
module lpc_wait_stop_ctrl
  import lpc_pkg::*;
#(
  parameter int OSC_DELAY = LPC_OSC_DELAY_CYCLES // oscillator cycles
) (
  input wire logic sys_clk, // core clock
  input wire logic srst, // synchronous reset, high
  input wire logic porFlag, // reset cause is power-on
  input wire logic stopExec, // stop instruction executing, pulse
  input wire logic haltUntilIrqExec, // wait opcode executing, pulse
  input wire logic stackDone, // cpu finished stacking, pulse
  input wire logic stopDisable, // condition code stop-disable flag
  input wire logic irqMask, // condition code interrupt mask flag
  input wire logic nmiMask, // condition code nonmaskable mask flag
  input wire logic [15:0] ccStackAddr, // where cc byte was stacked
  input wire logic irqPin_n, // maskable external request, low
  input wire logic irqEdgeLatched, // pending edge-triggered request
  input wire logic nonmaskableExtRequest_n, // nonmaskable pin, low
  input wire logic resetPin_n, // reset pin level, low
  input wire logic periphIrq, // any enabled internal interrupt
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  output logic cpuHalt, // cpu clocks off
  output logic oscEnable, // crystal oscillator running
  output logic periphClkEn, // peripheral clock tree
  output logic timerClkEn, // free-running timer clock
  output logic adcPowerEn, // converter supply on
  output logic spiClkEn, // serial peripheral clock
  output logic txClkEn, // transmitter clock
  output logic rxClkEn, // receiver clock
  output logic retainHold, // freeze pins, cpu state and ram
  output logic stackReq, // ask cpu to stack registers, pulse
  output logic busRdReq, // idle read cycle request, level
  output logic [15:0] busRdAddr, // idle read address
  output logic resumeNext, // continue after stop, pulse
  output logic serviceIrq, // fetch highest-priority vector, pulse
  output logic setMasks, // set nonmaskable and irq masks, pulse
  output logic stopNop, // stop treated as no-op, pulse
  output logic resetSeq // start normal reset sequence, pulse
);

  typedef struct packed {
    lpc_state_t state;
    lpc_act_t action;
    logic [15:0] dlyCnt;
    logic [5:0] ctrl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cpuHalt;
    logic oscEnable;
    logic periphClkEn;
    logic timerClkEn;
    logic adcPowerEn;
    logic spiClkEn;
    logic txClkEn;
    logic rxClkEn;
    logic retainHold;
    logic stackReq;
    logic busRdReq;
    logic [15:0] busRdAddr;
    logic resumeNext;
    logic serviceIrq;
    logic setMasks;
    logic stopNop;
    logic resetSeq;
  } lpc_regs_t;

  lpc_regs_t cur_ff;
  lpc_regs_t nxt_cur;

  localparam logic [15:0] DELAY_LAST = 16'(OSC_DELAY - 1);

  // maskable request as seen by the wake logic, level or latched edge
  function automatic logic irqActive(input logic pinN, input logic edgeP,
                                     input logic mask);
    irqActive = (!pinN || edgeP) && !mask;
  endfunction

  logic irqWake;
  logic nmiLow;
  logic waitWake;
  logic apbAccess;

  assign irqWake = irqActive(irqPin_n, irqEdgeLatched, irqMask);
  assign nmiLow = !nonmaskableExtRequest_n;
  // wait ends on any unmasked source, internal ones included
  assign waitWake = irqWake || (nmiLow && !nmiMask) ||
                    (periphIrq && !irqMask);
  assign apbAccess = psel && penable && !cur_ff.pready;

  always_comb begin
    nxt_cur = cur_ff;
    // pulses last one cycle unless re-asserted below
    nxt_cur.stackReq = 1'b0;
    nxt_cur.resumeNext = 1'b0;
    nxt_cur.serviceIrq = 1'b0;
    nxt_cur.setMasks = 1'b0;
    nxt_cur.stopNop = 1'b0;
    nxt_cur.resetSeq = 1'b0;
    nxt_cur.dlyCnt = LPC_CNT_ZERO;

    unique case (cur_ff.state)
      LPC_RUN: begin
        if (stopExec && !stopDisable) begin
          nxt_cur.state = LPC_STOP;
        end else if (stopExec) begin
          nxt_cur.stopNop = 1'b1;
        end else if (haltUntilIrqExec) begin
          nxt_cur.stackReq = 1'b1;
          nxt_cur.busRdAddr = ccStackAddr;
          nxt_cur.state = LPC_WAIT_STACK;
        end
      end
      LPC_WAIT_STACK: begin
        // idle reads begin only once the registers are safely stacked; cpuHalt is already high here
        if (stackDone) begin
          nxt_cur.state = LPC_WAIT_IDLE;
        end
      end
      LPC_WAIT_IDLE: begin
        if (waitWake) begin
          nxt_cur.serviceIrq = 1'b1;
          // nonmaskable wins priority, so both masks go up
          nxt_cur.setMasks = nmiLow && !nmiMask;
          nxt_cur.state = LPC_RUN;
        end
      end
      LPC_STOP: begin
        // reset pin first, then nonmaskable, then maskable
        if (!resetPin_n) begin
          nxt_cur.action = LPC_ACT_RESET;
          nxt_cur.ctrl[LPC_CTRL_RESTART_DELAY_EN] = 1'b1;
          nxt_cur.state = LPC_OSC_DELAY;
        end else if (nmiLow || irqWake) begin
          // masked nonmaskable wake just continues, nothing pending
          if (nmiLow && !nmiMask) begin
            nxt_cur.action = LPC_ACT_NMI;
          end else begin
            nxt_cur.action = LPC_ACT_RESUME;
          end
          nxt_cur.state = cur_ff.ctrl[LPC_CTRL_RESTART_DELAY_EN] ?
                          LPC_OSC_DELAY : LPC_WAKE_ACT;
        end
      end
      LPC_OSC_DELAY: begin
        // counts oscillator cycles once the oscillator is back on
        if (cur_ff.dlyCnt == DELAY_LAST) begin
          nxt_cur.state = LPC_WAKE_ACT;
        end else begin
          nxt_cur.dlyCnt = cur_ff.dlyCnt + LPC_CNT_ONE;
        end
      end
      LPC_WAKE_ACT: begin
        nxt_cur.state = LPC_RUN;
        unique case (cur_ff.action)
          LPC_ACT_RESUME: begin
            nxt_cur.resumeNext = 1'b1;
          end
          LPC_ACT_RESET: begin
            nxt_cur.resetSeq = 1'b1;
            nxt_cur.ctrl = LPC_CTRL_RESET;
          end
          LPC_ACT_NMI: begin
            nxt_cur.stackReq = 1'b1;
            nxt_cur.state = LPC_XSTACK;
          end
          LPC_ACT_NONE: begin
          end
        endcase
        nxt_cur.action = LPC_ACT_NONE;
      end
      LPC_XSTACK: begin
        // masks rise only after the condition code byte is on the stack
        if (stackDone) begin
          nxt_cur.serviceIrq = 1'b1;
          nxt_cur.setMasks = 1'b1;
          nxt_cur.state = LPC_RUN;
        end
      end
      default: begin
        nxt_cur.state = LPC_RUN;
      end
    endcase

    // apb slave: one wait state, then answer
    nxt_cur.pready = apbAccess;
    nxt_cur.pslverr = 1'b0;
    nxt_cur.prdata = 32'h0000_0000;
    if (apbAccess) begin
      if (paddr == LPC_ADDR_CTRL) begin
        if (pwrite && pstrb[0]) begin
          nxt_cur.ctrl = pwdata[5:0];
        end
        nxt_cur.prdata = {26'h000_0000, cur_ff.ctrl};
      end else if (paddr == LPC_ADDR_STATUS) begin
        // read-only; writes are dropped without error
        nxt_cur.prdata = {26'h000_0000, cur_ff.cpuHalt, cur_ff.action,
                          cur_ff.state};
      end else begin
        nxt_cur.pslverr = 1'b1;
      end
    end

    // a reset caught in stop must not lose its forced delay bit
    if (cur_ff.state == LPC_STOP && !resetPin_n) begin
      nxt_cur.ctrl[LPC_CTRL_RESTART_DELAY_EN] = 1'b1;
    end

    // clock gating, derived from the next state so outputs are registered
    nxt_cur.cpuHalt = nxt_cur.state != LPC_RUN;
    nxt_cur.oscEnable = nxt_cur.state != LPC_STOP;
    nxt_cur.periphClkEn = nxt_cur.state != LPC_STOP &&
                          nxt_cur.state != LPC_OSC_DELAY;
    nxt_cur.retainHold = nxt_cur.state == LPC_STOP ||
                         nxt_cur.state == LPC_OSC_DELAY;
    // timer keeps counting in wait unless nobody could need it
    nxt_cur.timerClkEn = nxt_cur.periphClkEn &&
                         !(nxt_cur.state == LPC_WAIT_IDLE && irqMask &&
                           nxt_cur.ctrl[LPC_CTRL_WATCHDOG_OFF]);
    nxt_cur.adcPowerEn = nxt_cur.periphClkEn &&
                         nxt_cur.ctrl[LPC_CTRL_CONV_POWER_UP];
    nxt_cur.spiClkEn = nxt_cur.periphClkEn &&
                       nxt_cur.ctrl[LPC_CTRL_SERIAL_EN];
    nxt_cur.txClkEn = nxt_cur.periphClkEn &&
                      nxt_cur.ctrl[LPC_CTRL_TX_EN];
    nxt_cur.rxClkEn = nxt_cur.periphClkEn &&
                      nxt_cur.ctrl[LPC_CTRL_RX_EN];
    nxt_cur.busRdReq = nxt_cur.state == LPC_WAIT_IDLE;
  end

  // single state register; reset picks delay only for power-on or
  // for a one-cycle reset that lands while the oscillator is stopped
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cur_ff <= '0;
      cur_ff.ctrl <= LPC_CTRL_RESET;
      cur_ff.oscEnable <= 1'b1;
      cur_ff.cpuHalt <= 1'b1;
      cur_ff.retainHold <= 1'b1;
      cur_ff.state <= (porFlag || cur_ff.state == LPC_STOP) ?
                      LPC_OSC_DELAY : LPC_RUN;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign prdata = cur_ff.prdata;
  assign pready = cur_ff.pready;
  assign pslverr = cur_ff.pslverr;
  assign cpuHalt = cur_ff.cpuHalt;
  assign oscEnable = cur_ff.oscEnable;
  assign periphClkEn = cur_ff.periphClkEn;
  assign timerClkEn = cur_ff.timerClkEn;
  assign adcPowerEn = cur_ff.adcPowerEn;
  assign spiClkEn = cur_ff.spiClkEn;
  assign txClkEn = cur_ff.txClkEn;
  assign rxClkEn = cur_ff.rxClkEn;
  assign retainHold = cur_ff.retainHold;
  assign stackReq = cur_ff.stackReq;
  assign busRdReq = cur_ff.busRdReq;
  assign busRdAddr = cur_ff.busRdAddr;
  assign resumeNext = cur_ff.resumeNext;
  assign serviceIrq = cur_ff.serviceIrq;
  assign setMasks = cur_ff.setMasks;
  assign stopNop = cur_ff.stopNop;
  assign resetSeq = cur_ff.resetSeq;

endmodule

/* File: test/lpc_cpu_model.sv */
// cpu sequencer stand-in: answers a stacking request after a set lag
// assumes stackReq is a one-cycle pulse on sys_clk
`timescale 1ns/1ps
module lpc_cpu_model (
  input wire logic sys_clk, // clock
  input wire logic srst, // reset
  input wire logic stackReq, // stacking request
  input wire logic [3:0] lag, // cycles spent stacking
  output logic stackDone // stacking finished
);
  logic [3:0] cnt_ff;
  logic busy_ff;
  // registers are pushed over lag cycles, never unasked
  always_ff @(posedge sys_clk) begin
    stackDone <= 1'b0;
    if (srst) begin
      busy_ff <= 1'b0;
    end else if (stackReq) begin
      busy_ff <= 1'b1;
      cnt_ff <= lag;
    end else if (busy_ff && cnt_ff == 4'h0) begin
      busy_ff <= 1'b0;
      stackDone <= 1'b1;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule

/* File: test/lpc_wait_stop_ctrl_checker.sv */
// port-level checks of the wait/stop sequencer
// assumes one clock and a sync reset; bound onto the top module
`timescale 1ns/1ps
module lpc_wait_stop_ctrl_checker #(
  parameter int OSC_DELAY = 8 // restart delay in cycles
) (
  input wire logic sys_clk, // clock
  input wire logic srst, // reset
  input wire logic stopExec, // stop op
  input wire logic haltUntilIrqExec, // wait op
  input wire logic stopDisable, // stop-disable flag
  input wire logic irqMask, // irq mask flag
  input wire logic nmiMask, // nmi mask flag
  input wire logic irqPin_n, // irq pin
  input wire logic irqEdgeLatched, // latched edge irq
  input wire logic nonmaskableExtRequest_n, // nmi pin
  input wire logic resetPin_n, // reset pin
  input wire logic periphIrq, // internal irq
  input wire logic cpuHalt, // cpu off
  input wire logic oscEnable, // oscillator on
  input wire logic periphClkEn, // peripheral clocks
  input wire logic timerClkEn, // timer clock
  input wire logic retainHold, // state frozen
  input wire logic stackReq, // stack request
  input wire logic busRdReq, // idle reads
  input wire logic [15:0] busRdAddr, // idle read address
  input wire logic resumeNext, // resume pulse
  input wire logic serviceIrq, // service pulse
  input wire logic stopNop, // nop pulse
  input wire logic resetSeq // reset pulse
);
  // slowest wake path: delay, wake cycle, pulse, margin
  localparam int WAKE_MAX = OSC_DELAY + 4;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // oscillator off with state frozen marks the stop state
  sequence sStopped;
    !oscEnable && retainHold;
  endsequence
  sequence sRunStop;
    stopExec && !cpuHalt;
  endsequence
  chk_stop_nop: assert property (sRunStop ##0 stopDisable |=> stopNop)
    else $error("stop not treated as nop");
  chk_stop_entry: assert property (sRunStop ##0 !stopDisable
    |=> sStopped ##0 !periphClkEn) else $error("stop not entered");
  chk_stop_frozen: assert property (sStopped |-> !periphClkEn &&
    !timerClkEn) else $error("clock running in stop");
  chk_irq_masked: assert property (sStopped ##0 resetPin_n &&
    nonmaskableExtRequest_n && irqMask && !irqPin_n |=> !oscEnable)
    else $error("masked irq woke stop");
  chk_irq_wake: assert property (sStopped ##0 resetPin_n &&
    nonmaskableExtRequest_n && !irqMask && (!irqPin_n || irqEdgeLatched)
    |-> ##[1:WAKE_MAX] resumeNext) else $error("irq did not wake");
  chk_reset_wake: assert property (sStopped ##0 !resetPin_n
    |-> ##[1:WAKE_MAX] resetSeq) else $error("reset pin did not wake");
  chk_nmi_masked: assert property (sStopped ##0 resetPin_n &&
    !nonmaskableExtRequest_n && nmiMask
    |-> !stackReq throughout ##[1:WAKE_MAX] resumeNext)
    else $error("masked nmi wake wrong");
  chk_nmi_serve: assert property (sStopped ##0 resetPin_n &&
    !nonmaskableExtRequest_n && !nmiMask |-> ##[1:WAKE_MAX] stackReq)
    else $error("nmi wake not stacked");
  chk_wait_stack: assert property (!cpuHalt && haltUntilIrqExec &&
    !stopExec |=> stackReq && cpuHalt) else $error("wait not stacked");
  chk_wait_idle: assert property (busRdReq |-> oscEnable &&
    cpuHalt && $stable(busRdAddr)) else $error("wait idle wrong");
  chk_wait_wake: assert property (busRdReq && periphIrq &&
    !irqMask |=> serviceIrq && !busRdReq) else $error("wait not left");
  chk_timer_gate: assert property (busRdReq && !$past(irqMask)
    |-> timerClkEn) else $error("timer stopped while unmasked");
endmodule

bind lpc_wait_stop_ctrl lpc_wait_stop_ctrl_checker
  #(.OSC_DELAY(OSC_DELAY)) chk_i (.*);

/* File: test/lpc_wait_stop_ctrl_test.sv */
// self-checking bench for the wait/stop sequencer
// assumes one 200 MHz clock; far side cpu is lpc_cpu_model
`timescale 1ns/1ps
module lpc_wait_stop_ctrl_test;
  import lpc_pkg::*;
  localparam int OD = 8; // short restart delay for simulation
  logic sys_clk, srst, porFlag, stopExec, haltUntilIrqExec, stackDone;
  logic stopDisable, irqMask, nmiMask, irqPin_n, irqEdgeLatched;
  logic nonmaskableExtRequest_n, resetPin_n, periphIrq, err;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, lag;
  logic [15:0] ccStackAddr, busRdAddr;
  logic cpuHalt, oscEnable, periphClkEn, timerClkEn, adcPowerEn, spiClkEn;
  logic txClkEn, rxClkEn, retainHold, stackReq, busRdReq, resumeNext;
  logic serviceIrq, setMasks, stopNop, resetSeq;
  logic [6:0] ev;
  int numErrors = 0;
  int cmpCount = 0;
  int n;
  // events waited on, by index
  assign ev = {~cpuHalt, resetSeq, serviceIrq, resumeNext, stackReq,
    stopNop, busRdReq};
  lpc_wait_stop_ctrl #(.OSC_DELAY(OD)) uut (.*);
  lpc_cpu_model cpu (.sys_clk(sys_clk), .srst(srst), .stackReq(stackReq),
    .lag(lag), .stackDone(stackDone));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmpCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    if (numErrors == 0 && cmpCount > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // bounded wait; values are read as they stood before the edge
  task automatic waitEv(input int i, output int c);
    c = 0;
    do begin
      @(posedge sys_clk);
      c++;
    end while (ev[i] !== 1'b1 && c < 80);
    if (ev[i] !== 1'b1) begin
      chk("event timeout", i, 99);
      results;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) begin
      chk("apb timeout", 0, 1);
      results;
    end
  endtask
  task automatic rst(input logic por);
    @(posedge sys_clk);
    {srst, porFlag} <= {1'b1, por};
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    waitEv(6, n);
  endtask
  // one-cycle opcode pulse: 1 is the wait opcode, 0 is stop
  task automatic op(input logic w);
    @(posedge sys_clk);
    {haltUntilIrqExec, stopExec} <= {w, ~w};
    @(posedge sys_clk);
    {stopExec, haltUntilIrqExec} <= 2'b00;
  endtask
  task automatic stopWake(input int w, input int i);
    op(1'b0);
    repeat (4) @(posedge sys_clk);
    chk("stopped", {oscEnable, retainHold, periphClkEn}, 3'b010);
    case (w)
      0: irqPin_n <= 1'b0;
      1: irqEdgeLatched <= 1'b1;
      2: nonmaskableExtRequest_n <= 1'b0;
      default: resetPin_n <= 1'b0;
    endcase
    waitEv(i, n);
    {irqPin_n, irqEdgeLatched, nonmaskableExtRequest_n, resetPin_n} <= 4'hb;
  endtask
  initial begin
    {srst, porFlag, stopExec, haltUntilIrqExec, stopDisable} = 5'h18;
    {irqMask, nmiMask, irqEdgeLatched, periphIrq, psel, penable} = 6'h0;
    {irqPin_n, nonmaskableExtRequest_n, resetPin_n, pwrite} = 4'he;
    {paddr, pwdata, pstrb, ccStackAddr, lag} = 64'h0f01f70;
    rst(1'b1);
    chk("por delay", n >= OD, 1);
    rst(1'b0);
    chk("warm reset", n < OD, 1);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", {rd, adcPowerEn}, 33'h2);
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped", err, 1);
    apb(1'b1, 8'h00, 32'h1e);
    repeat (2) @(posedge sys_clk);
    chk("enables", {adcPowerEn, spiClkEn, txClkEn, rxClkEn}, 4'hf);
    stopDisable <= 1'b1;
    op(1'b0);
    waitEv(1, n);
    chk("stop nop", {n[3:0], oscEnable}, 5'h3);
    stopDisable <= 1'b0;
    stopWake(0, 3);
    chk("irq wake", n, 3);
    chk("resumed", {cpuHalt, adcPowerEn, spiClkEn, txClkEn, rxClkEn}, 5'hf);
    stopWake(1, 3);
    chk("edge wake", n, 3);
    {irqMask, nmiMask, irqPin_n} <= 3'b110;
    stopWake(2, 3);
    chk("masked nmi", {n[3:0], stackReq}, 5'h6);
    {irqMask, nmiMask, lag} <= 6'h05;
    stopWake(2, 2);
    chk("nmi stack", n, 3);
    waitEv(4, n);
    chk("nmi masks", setMasks, 1);
    stopWake(3, 5);
    chk("reset wake", n >= OD, 1);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl after reset", rd, 32'h1);
    stopWake(0, 3);
    chk("delayed wake", n >= OD, 1);
    apb(1'b1, 8'h00, 32'h21);
    irqMask <= 1'b1;
    op(1'b1);
    waitEv(0, n);
    chk("idle", {busRdAddr, timerClkEn, oscEnable, cpuHalt}, 19'hfbb);
    periphIrq <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("masked periph", busRdReq, 1);
    irqMask <= 1'b0;
    waitEv(4, n);
    chk("periph wake", {busRdReq, setMasks}, 2'b00);
    periphIrq <= 1'b0;
    op(1'b1);
    waitEv(0, n);
    chk("timer runs", timerClkEn, 1);
    nonmaskableExtRequest_n <= 1'b0;
    waitEv(4, n);
    chk("ext wake", setMasks, 1);
    results;
  end
endmodule
